// *** design/lso_pkg.sv ***
// Purpose: Shared constants and types for the laser status output block.
// Assumes: A 100 MHz system clock and a 32-bit AHB-Lite register port.
// Notes: Every offset, field position, reset value and timing count.

package lso_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned INHIBIT_S = 5;
    localparam int unsigned INHIBIT_CYCLES = INHIBIT_S * CLK_HZ;
    localparam int TMR_W = 32;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_TIMER = 8'h10;
    localparam int CTRL_EN = 0;
    localparam int CTRL_TEMP_CLR = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam int ST_READY = 0;
    localparam int ST_SHUT = 1;
    localparam int ST_EMIT = 2;
    localparam int ST_FAULT = 3;
    localparam int ST_ILK_OPEN = 4;
    localparam int ST_TEMP = 5;
    localparam int ST_ARMED = 6;
    localparam int ST_NOSTRIKE = 7;

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    localparam int EVT_W = 4;
    localparam int EVT_READY_UP = 0;
    localparam int EVT_ILK_LOST = 1;
    localparam int EVT_FAULT = 2;
    localparam int EVT_ARMED = 3;
    localparam logic [3:0] MASK_RST = 4'h0;

    typedef enum logic [1:0] {
        LSO_DISABLED,
        LSO_COUNTDOWN,
        LSO_ARMED
    } lso_state_e;
endpackage : lso_pkg

// *** design/lso_core_if.sv ***
// Purpose: Carries timer and interrupt signals between the block's modules.
// Assumes: One clock domain shared by every party.
// Notes: The core drives requests, the leaves answer.

interface lso_core_if;
    logic run;
    logic done;
    logic [lso_pkg::TMR_W-1:0] remain;
    logic [lso_pkg::EVT_W-1:0] evt;
    logic clr_we;
    logic mask_we;
    logic [lso_pkg::EVT_W-1:0] wdata;
    logic [lso_pkg::EVT_W-1:0] stat;
    logic [lso_pkg::EVT_W-1:0] mask;
    logic irq;
    modport core(output run, evt, clr_we, mask_we, wdata,
                 input done, remain, stat, mask, irq);
    modport tmr(input run, output done, remain);
    modport irqm(input evt, clr_we, mask_we, wdata,
                 output stat, mask, irq);
endinterface : lso_core_if

// *** design/lso_inhibit_timer.sv ***
// Purpose: Lasing inhibit countdown that runs while the laser is ready.
// Assumes: CYCLES is at least one.
// Notes: Dropping run reloads the count, so every regain restarts it.

module lso_inhibit_timer #(
    parameter int unsigned CYCLES = lso_pkg::INHIBIT_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    lso_core_if.tmr tmr
);
    localparam int W = lso_pkg::TMR_W;
    localparam logic [W-1:0] LOAD = W'(CYCLES);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    wire cnt_zero = (cnt == '0);

    assign next_cnt = !tmr.run ? LOAD : (cnt_zero ? cnt : cnt - 1'b1); // R11
    assign tmr.done = tmr.run && cnt_zero; // R5
    assign tmr.remain = cnt;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= LOAD;
        end else begin
            cnt <= next_cnt;
        end
    end

    a_timer_reload: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !tmr.run |=> cnt == LOAD) // R11
        else $error("inhibit count not reloaded while idle");
    a_timer_steps: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tmr.run && !cnt_zero |=> cnt == $past(cnt) - 1'b1) // R5
        else $error("inhibit count did not step down");
endmodule : lso_inhibit_timer

// *** design/lso_irq.sv ***
// Purpose: Sticky event flags, their mask and the interrupt level.
// Assumes: Clear is a write of ones, applied for one cycle.
// Notes: An event in the clearing cycle survives the clear.

module lso_irq (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    lso_core_if.irqm irqm
);
    localparam int W = lso_pkg::EVT_W;

    logic [W-1:0] stat;
    logic [W-1:0] mask;
    wire [W-1:0] clr_bits = irqm.clr_we ? irqm.wdata : '0;
    wire [W-1:0] next_stat = (stat & ~clr_bits) | irqm.evt;
    wire [W-1:0] next_mask = irqm.mask_we ? irqm.wdata : mask;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat <= '0;
            mask <= lso_pkg::MASK_RST;
        end else begin
            stat <= next_stat;
            mask <= next_mask;
        end
    end

    assign irqm.stat = stat;
    assign irqm.mask = mask;
    assign irqm.irq = |(stat & mask);

    a_irq_set_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (irqm.evt != '0) |=> (stat & $past(irqm.evt)) == $past(irqm.evt))
        else $error("event lost against a clear");
endmodule : lso_irq

// *** design/lso_status_top.sv ***
// Purpose: Status outputs and lasing permission of the laser controller.
// Assumes: All user inputs are synchronous to mclk_i and already cleaned.
// Notes: An output value of one means the switched output is closed.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.

// Notes on behaviour
// R1: Shutter status stays open unless request, closed interlock and ready.
// R2: Emission status is closed exactly while a beam is being emitted.
// R3: Fault status is closed on over-temperature or no-strike, else open.
// R4: Ready status is closed while the laser is enabled, open otherwise.
// R5: Lasing is inhibited for five seconds after ready first closes.
// R6: Shutter status needs interlock and request, and opens when disabled.
// R7: Interlock-open status is closed while the interlock circuit is open.
// R8: Restoring the interlock starts a five-second lasing inhibit.
// R9: A held start request disables; its release readies and counts down.
// R10: Interlock loss drops ready, shutter and drive power, unlatched.
// R11: The inhibit restarts on each regain; outputs come from flip-flops.
module lso_status_top #(
    parameter int unsigned INHIBIT_CYCLES = lso_pkg::INHIBIT_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic interlock_i,
    input wire logic shutter_req_i,
    input wire logic start_hold_i,
    input wire logic modulation_i,
    input wire logic over_temp_i,
    input wire logic no_strike_i,
    output logic emission_lamp_o,
    output logic fault_o,
    output logic ready_o,
    output logic shutter_lamp_o,
    output logic interlock_open_o,
    output logic thermal_lamp_o,
    output logic rf_power_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------
    // One flop stage on every laser input keeps decisions on a stable copy.
    logic ilk_q;
    logic shut_q;
    logic start_q;
    logic mod_q;
    logic temp_q;
    logic nostr_q;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ilk_q <= 1'b0;
            shut_q <= 1'b0;
            start_q <= 1'b0;
            mod_q <= 1'b0;
            temp_q <= 1'b0;
            nostr_q <= 1'b0;
        end else begin
            ilk_q <= interlock_i;
            shut_q <= shutter_req_i;
            start_q <= start_hold_i;
            mod_q <= modulation_i;
            temp_q <= over_temp_i;
            nostr_q <= no_strike_i;
        end
    end

    // ------------------------------------------------------------
    // Shared carrier and leaf modules
    // ------------------------------------------------------------
    lso_core_if core_if ();

    // A small CYCLES value only shortens simulation; hardware keeps the
    // five-second default.
    lso_inhibit_timer #(
        .CYCLES(INHIBIT_CYCLES)
    ) u_timer (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .tmr(core_if.tmr)
    );

    lso_irq u_irq (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .irqm(core_if.irqm)
    );

    // ------------------------------------------------------------
    // Bus address phase and decode
    // ------------------------------------------------------------
    // Zero wait states: every transfer completes in its first data cycle.
    // Read data is taken at the address edge, so a read right behind a
    // write to the same word still returns the value from before it.
    logic [1:0] ctrl;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    wire bus_take = hsel_i && htrans_i[1] && hready_i;
    wire [7:0] aph_addr = haddr_i[7:0];
    wire hit_ctrl = (dph_addr == lso_pkg::OFS_CTRL);
    wire hit_istat = (dph_addr == lso_pkg::OFS_IRQ_STAT);
    wire hit_imask = (dph_addr == lso_pkg::OFS_IRQ_MASK);
    wire wr_ctrl = dph_wr && hit_ctrl;
    wire wr_istat = dph_wr && hit_istat;
    wire wr_imask = dph_wr && hit_imask;
    wire temp_clr_req = wr_ctrl && hwdata_i[lso_pkg::CTRL_TEMP_CLR];

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (aph_addr)
            lso_pkg::OFS_CTRL: rd_mux[1:0] = ctrl;
            lso_pkg::OFS_STATUS: rd_mux = status_word;
            lso_pkg::OFS_IRQ_STAT: rd_mux[3:0] = core_if.stat;
            lso_pkg::OFS_IRQ_MASK: rd_mux[3:0] = core_if.mask;
            lso_pkg::OFS_TIMER: rd_mux = core_if.remain;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dph_wr <= 1'b0;
            dph_addr <= 8'h00;
            hrdata_o <= 32'h0000_0000;
        end else begin
            dph_wr <= bus_take && hwrite_i;
            dph_addr <= aph_addr;
            hrdata_o <= (bus_take && !hwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // The clear bit is a strobe and never reads back as one.
    wire [1:0] next_ctrl = wr_ctrl ?
        {1'b0, hwdata_i[lso_pkg::CTRL_EN]} : {1'b0, ctrl[lso_pkg::CTRL_EN]};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl <= lso_pkg::CTRL_RST;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ------------------------------------------------------------
    // Laser state decisions
    // ------------------------------------------------------------
    // Over-temperature latches until the part is cool and software
    // clears it; this stands in for the power cycle that a stand-alone
    // unit would need. A still-hot input wins over the clear.
    logic temp_latch;
    lso_pkg::lso_state_e state;
    lso_pkg::lso_state_e next_state;

    wire next_temp = temp_q || (temp_latch && !temp_clr_req); // R3
    wire sw_enable = ctrl[lso_pkg::CTRL_EN];
    // Interlock faults are not latched: ready follows the input.
    wire next_ready = ilk_q && !start_q && sw_enable && !next_temp; // R4 R9 R10
    wire next_shut = ilk_q && shut_q && next_ready; // R1 R6 R10
    wire next_fault = next_temp || nostr_q; // R3
    wire next_ilk_open = !ilk_q; // R7
    // Emission needs the countdown finished; done drops with ready.
    wire next_emit = next_shut && core_if.done && mod_q && !nostr_q; // R2 R5 R8

    always_comb begin
        next_state = state;
        unique case (state)
            lso_pkg::LSO_DISABLED:
                if (next_ready) next_state = lso_pkg::LSO_COUNTDOWN; // R9
            lso_pkg::LSO_COUNTDOWN:
                if (!next_ready) next_state = lso_pkg::LSO_DISABLED;
                else if (core_if.done) next_state = lso_pkg::LSO_ARMED; // R5
            lso_pkg::LSO_ARMED:
                if (!next_ready) next_state = lso_pkg::LSO_DISABLED; // R11
        endcase
    end

    // ------------------------------------------------------------
    // Registered status outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temp_latch <= 1'b0;
            state <= lso_pkg::LSO_DISABLED;
            ready_o <= 1'b0;
            shutter_lamp_o <= 1'b0;
            fault_o <= 1'b0;
            interlock_open_o <= 1'b1;
            emission_lamp_o <= 1'b0;
        end else begin
            temp_latch <= next_temp;
            state <= next_state;
            ready_o <= next_ready; // R11
            shutter_lamp_o <= next_shut; // R11
            fault_o <= next_fault; // R11
            interlock_open_o <= next_ilk_open; // R11
            emission_lamp_o <= next_emit; // R11
        end
    end

    assign thermal_lamp_o = temp_latch;
    // Drive power follows ready, so interlock loss removes it at once.
    assign rf_power_o = ready_o; // R10
    // The countdown runs only while ready is closed; a ready edge,
    // including one caused by the interlock closing, restarts it.
    assign core_if.run = ready_o; // R5 R8 R9 R11

    // Bit seven is the sampled no-strike input, not a latched copy.
    assign status_word = {24'h00_0000, nostr_q,
                          (state == lso_pkg::LSO_ARMED), temp_latch,
                          interlock_open_o, fault_o, emission_lamp_o,
                          shutter_lamp_o, ready_o};

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    // Events are edges of the next values, so each flag sets in the same
    // cycle as the output that it reports.
    wire ev_ready_up = next_ready && !ready_o;
    wire ev_ilk_lost = next_ilk_open && !interlock_open_o;
    wire ev_fault = next_fault && !fault_o;
    wire ev_armed = (state == lso_pkg::LSO_COUNTDOWN) &&
                    (next_state == lso_pkg::LSO_ARMED);

    assign core_if.evt = {ev_armed, ev_fault, ev_ilk_lost, ev_ready_up};
    assign core_if.clr_we = wr_istat;
    assign core_if.mask_we = wr_imask;
    assign core_if.wdata = hwdata_i[3:0];
    assign irq_o = core_if.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_shutter_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        shutter_lamp_o |-> ready_o && $past(ilk_q) && $past(shut_q)) // R1
        else $error("shutter closed without request and ready");
    a_shutter_follows: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        ilk_q && shut_q && next_ready |=> shutter_lamp_o) // R6
        else $error("shutter status missed a valid request");
    a_emit_needs_beam: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        emission_lamp_o |-> shutter_lamp_o && $past(mod_q)) // R2
        else $error("emission shown with no beam");
    a_emit_follows: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        next_shut && core_if.done && mod_q && !nostr_q
        |=> emission_lamp_o) // R2
        else $error("emission status missed an emitted beam");
    a_fault_cause: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (temp_q || nostr_q) |=> fault_o) // R3
        else $error("fault status missed a fault");
    a_fault_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !next_temp && !nostr_q |=> !fault_o) // R3
        else $error("fault status stuck closed");
    a_ready_level: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ready_o == $past(next_ready)) // R4
        else $error("ready status does not follow enable");
    a_inhibit_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(ready_o) |-> !emission_lamp_o [*2]) // R5
        else $error("lasing during inhibit interval");
    a_emit_armed: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(emission_lamp_o) |-> $past(core_if.done)) // R5
        else $error("emission before countdown end");
    a_ilk_open: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !ilk_q |=> interlock_open_o && !ready_o) // R7
        else $error("interlock open not shown");
    a_ilk_restore: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $fell(interlock_open_o) |-> !emission_lamp_o [*2]) // R8
        else $error("lasing right after interlock restore");
    a_start_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        start_q |=> !ready_o && !rf_power_o) // R9
        else $error("start request did not disable");
    a_ilk_loss: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $fell(interlock_i) |=> ##1 !shutter_lamp_o && !rf_power_o) // R10
        else $error("interlock loss left drive on");
    a_timer_restart: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        $fell(ready_o) |-> state == lso_pkg::LSO_DISABLED) // R11
        else $error("state kept armed after enable loss");

    // ------------------------------------------------------------
    // Checks on the enable chain
    // ------------------------------------------------------------
    // A slip in any one term of ready would show here first.
    a_shut_disabled: assert property (@(posedge mclk_i) // R6
        disable iff (!rst_n_i) !ready_o |-> !shutter_lamp_o)
        else $error("shutter shown while disabled");
    a_shut_drop: assert property (@(posedge mclk_i) // R1
        disable iff (!rst_n_i) (!ilk_q || !shut_q) |=> !shutter_lamp_o)
        else $error("shutter kept without interlock and request");
    a_ilk_closed: assert property (@(posedge mclk_i) // R7
        disable iff (!rst_n_i) ilk_q |=> !interlock_open_o)
        else $error("interlock open shown with interlock closed");
    a_rf_off: assert property (@(posedge mclk_i) // R10
        disable iff (!rst_n_i) !ilk_q |=> !rf_power_o)
        else $error("drive power kept after interlock loss");
    a_ilk_unlatched: assert property (@(posedge mclk_i) // R10
        disable iff (!rst_n_i)
        ilk_q && !start_q && sw_enable && !next_temp |=> ready_o)
        else $error("ready not regained after interlock return");

    a_start_release: assert property (@(posedge mclk_i) // R9
        disable iff (!rst_n_i)
        $fell(start_q) && ilk_q && sw_enable && !next_temp
        |=> ready_o && state == lso_pkg::LSO_COUNTDOWN)
        else $error("start release did not begin the countdown");
    a_ready_disable: assert property (@(posedge mclk_i) // R4
        disable iff (!rst_n_i) !sw_enable |=> !ready_o)
        else $error("ready shown while software disabled");
    a_emit_in_armed: assert property (@(posedge mclk_i) // R5
        disable iff (!rst_n_i)
        emission_lamp_o |-> state == lso_pkg::LSO_ARMED)
        else $error("emission outside the armed state");
    a_armed_done: assert property (@(posedge mclk_i) // R5
        disable iff (!rst_n_i)
        state == lso_pkg::LSO_ARMED |-> core_if.done)
        else $error("armed state without finished countdown");
    a_emit_no_mod: assert property (@(posedge mclk_i) // R2
        disable iff (!rst_n_i) !mod_q |=> !emission_lamp_o)
        else $error("emission shown with no modulation");

    a_fault_nostrike: assert property (@(posedge mclk_i) // R3
        disable iff (!rst_n_i) nostr_q |=> fault_o && !emission_lamp_o)
        else $error("no-strike not shown as fault");
    a_temp_holds: assert property (@(posedge mclk_i) // R3
        disable iff (!rst_n_i)
        temp_latch && !temp_clr_req |=> temp_latch && fault_o)
        else $error("over-temperature latch lost without clear");
    a_temp_clears: assert property (@(posedge mclk_i) // R3
        disable iff (!rst_n_i)
        temp_latch && temp_clr_req && !temp_q |=> !temp_latch)
        else $error("over-temperature latch ignored a clear");
endmodule : lso_status_top

// *** test/lso_plc_model.sv ***
// Purpose: Behavioural machine controller that drives the laser inputs.
// Assumes: Commands change right after a rising edge of mclk_i.
// Notes: The bench calls set_cmd to move every command line at once.

module lso_plc_model (
    input wire logic mclk_i,
    output logic interlock_o,
    output logic shutter_req_o,
    output logic start_hold_o,
    output logic modulation_o,
    output logic over_temp_o,
    output logic no_strike_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Command lines
    // ------------------------------------------------------------
    // All lines start inactive so the laser powers up disabled.
    logic [5:0] cmd = 6'h00;

    assign interlock_o = cmd[5];
    assign shutter_req_o = cmd[4];
    assign start_hold_o = cmd[3];
    assign modulation_o = cmd[2];
    assign over_temp_o = cmd[1];
    assign no_strike_o = cmd[0];

    // Order: interlock, shutter request, start hold, modulation,
    // over-temperature, no-strike.
    task automatic set_cmd(input logic [5:0] c);
        @(posedge mclk_i);
        cmd <= c;
    endtask : set_cmd
endmodule : lso_plc_model

// *** test/tb_lso_status_top.sv ***
// Purpose: Self-checking bench for the laser status output block.
// Assumes: Zero-wait AHB-Lite slave; inhibit shortened to 20 cycles.
// Notes: Lamp vector order is emission, fault, ready, shutter,
// interlock-open, thermal, drive power.

module tb_lso_status_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned INH = 20;
    logic mclk_i, rst_n_i, hsel, hwrite, hready, hresp, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic il, sr, sh, md, ot, ns;
    logic em, fl, rdy, shutter_lamp, io, th, rf;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;

    lso_plc_model plc (.mclk_i(mclk_i), .interlock_o(il),
        .shutter_req_o(sr), .start_hold_o(sh), .modulation_o(md),
        .over_temp_o(ot), .no_strike_o(ns));

    lso_status_top #(.INHIBIT_CYCLES(INH)) dut (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
        .hresp_o(hresp), .hrdata_o(hrdata), .interlock_i(il),
        .shutter_req_i(sr), .start_hold_i(sh), .modulation_i(md),
        .over_temp_i(ot), .no_strike_i(ns), .emission_lamp_o(em),
        .fault_o(fl), .ready_o(rdy), .shutter_lamp_o(shutter_lamp),
        .interlock_open_o(io), .thermal_lamp_o(th), .rf_power_o(rf),
        .irq_o(irq));

    // ------------------------------------------------------------
    // Clock, reset and hang guard
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // A hang in a bus wait would stall forever, so cycles are capped.
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cyc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic lamps(input logic [6:0] exp);
        chk({25'h0, em, fl, rdy, shutter_lamp, io, th, rf}, {25'h0, exp});
    endtask : lamps

    // The address phase is held until hready is seen high at an edge.
    task automatic ahb(input logic [7:0] ofs, input logic wr,
                       input logic [31:0] wd, output logic [31:0] rdv);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        do @(posedge mclk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? wd : 32'h0;
        do @(posedge mclk_i); while (hready !== 1'b1);
        rdv = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(ofs, 1'b1, d, dummy);
    endtask : wr

    task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
        ahb(ofs, 1'b0, 32'h0, rd);
        chk(rd, exp);
    endtask : rdchk

    task automatic results();
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cyc(16);
        rst_n_i <= 1'b1;
        cyc(3);
        lamps(7'b0000100);
        rdchk(lso_pkg::OFS_CTRL, 32'h1);
        rdchk(lso_pkg::OFS_IRQ_MASK, 32'h0);
        rdchk(8'h20, 32'h0);
        rdchk(lso_pkg::OFS_TIMER, INH);
        chk({31'h0, hresp}, 32'h0);
        wr(lso_pkg::OFS_IRQ_STAT, 32'hf);
        $display("test reset done");

        // Held start request keeps the laser disabled.
        plc.set_cmd(6'b111100);
        cyc(40);
        lamps(7'b0000000);
        plc.set_cmd(6'b110100);
        cyc(10);
        lamps(7'b0011001);
        cyc(25);
        lamps(7'b1011001);
        rdchk(lso_pkg::OFS_STATUS, 32'h47);
        plc.set_cmd(6'b110000);
        cyc(3);
        lamps(7'b0011001);
        plc.set_cmd(6'b100100);
        cyc(3);
        lamps(7'b0010001);
        $display("test ready and inhibit done");

        // Interlock loss with the loss event unmasked.
        wr(lso_pkg::OFS_IRQ_STAT, 32'hf);
        wr(lso_pkg::OFS_IRQ_MASK, 32'h2);
        plc.set_cmd(6'b010100);
        cyc(3);
        lamps(7'b0000100);
        chk({31'h0, irq}, 32'h1);
        rdchk(lso_pkg::OFS_IRQ_STAT, 32'h2);
        wr(lso_pkg::OFS_IRQ_MASK, 32'h0);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(lso_pkg::OFS_IRQ_STAT, 32'h2);
        rdchk(lso_pkg::OFS_IRQ_STAT, 32'h0);
        plc.set_cmd(6'b110100);
        cyc(10);
        lamps(7'b0011001);
        cyc(25);
        lamps(7'b1011001);
        $display("test interlock done");

        // No-strike and a latched over-temperature.
        plc.set_cmd(6'b110101);
        cyc(3);
        lamps(7'b0111001);
        plc.set_cmd(6'b110100);
        cyc(3);
        lamps(7'b1011001);
        plc.set_cmd(6'b110110);
        cyc(3);
        lamps(7'b0100010);
        plc.set_cmd(6'b110100);
        cyc(3);
        lamps(7'b0100010);
        wr(lso_pkg::OFS_CTRL, 32'h3);
        cyc(4);
        lamps(7'b0011001);
        rdchk(lso_pkg::OFS_IRQ_STAT, 32'hd);
        $display("test fault done");

        // Software disable drops ready and shutter.
        wr(lso_pkg::OFS_CTRL, 32'h0);
        cyc(4);
        lamps(7'b0000000);
        rdchk(lso_pkg::OFS_CTRL, 32'h0);
        $display("test disable done");

        // A second reset in mid-run brings the enable back on.
        rst_n_i <= 1'b0;
        cyc(2);
        lamps(7'b0000100);
        rst_n_i <= 1'b1;
        cyc(3);
        lamps(7'b0011001);
        rdchk(lso_pkg::OFS_CTRL, 32'h1);
        $display("test reset again done");
        results();
    end
endmodule : tb_lso_status_top
